// >>> src/qss_status_top.sv
// Status summary block: questionable, operation and temperature registers.
// Assumes lower sub-register event words arrive synchronous to clk_i.
// How it works
// - Power, temperature, frequency summaries sit at questionable bits 3, 4, 5.
// - Calibration summary at bit 8, integrity summary at bit 9.
// - Condition read of a summary bit is OR of its sub-register events.
// - Event bits latch filtered rising or falling transitions of their own condition bits.
// - Summaries come from lower event bits, never lower condition bits.
// - Detection logs listed number; clearing logs listed number plus 1000.
// - Summary bits log nothing; reserved numbers are 601 plus two per bit.
// - Operation bits log nothing unless marked otherwise.
// - DC coupled is operation bit 10, logging 721 and 1721.
// - In list-sequencer mode bit 9 shows the sequencer running.
// - In receiver mode bit 9 shows scan results available.
// - Temperature bit 0 is oven cold, logging 801 and 1801, summary bit 4.
// - Power summarizes into bit 3, frequency into bit 5.
`timescale 1ns/1ps
`include "qss_map.svh"
module qss_status_top #(
  parameter int W = `QSS_REG_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] power_evt_i,
  input wire logic [W-1:0] freq_evt_i,
  input wire logic [W-1:0] cal_evt_i,
  input wire logic [W-1:0] integ_evt_i,
  input wire logic [W-1:0] oper_cond_i,
  input wire logic oven_cold_i,
  input wire logic dc_coupled_i,
  input wire logic seq_running_i,
  input wire logic scan_ready_i,
  input wire qss_pkg::qss_mode_t mode_i,
  input wire logic [W-1:0] ques_ptr_i,
  input wire logic [W-1:0] ques_ntr_i,
  input wire logic [W-1:0] oper_ptr_i,
  input wire logic [W-1:0] oper_ntr_i,
  input wire logic [W-1:0] temp_ptr_i,
  input wire logic [W-1:0] temp_ntr_i,
  input wire qss_pkg::qss_query_t query_i,
  output logic [W-1:0] rdata_o,
  output logic rvalid_o,
  output qss_pkg::qss_event_t event_o
);
  if (W <= `QSS_OB_DC_COUPLED || W > 16)
  begin : g_bad_w
    $error("qss_status_top: bad width");
  end
  // ---------------------------------------------------------------------------
  // Condition words
  // ---------------------------------------------------------------------------
  logic [W-1:0] temp_cond;
  logic [W-1:0] temp_evt;
  logic [W-1:0] oper_cond;
  logic [W-1:0] oper_evt;
  logic [W-1:0] ques_cond;
  logic [W-1:0] ques_evt;
  logic [W-1:0] temp_rise;
  logic [W-1:0] temp_fall;
  logic [W-1:0] oper_rise;
  logic [W-1:0] oper_fall;
  logic clr_ques;
  logic clr_oper;
  logic clr_temp;
  always_comb
  begin
    temp_cond = '0;
    temp_cond[`QSS_TB_OVEN_COLD] = oven_cold_i;
  end
  always_comb
  begin
    oper_cond = oper_cond_i;
    oper_cond[`QSS_OB_DC_COUPLED] = dc_coupled_i;
    case (mode_i)
      qss_pkg::QSS_LIST_SEQ: oper_cond[`QSS_OB_SRC_SWEEP] = seq_running_i;
      qss_pkg::QSS_RECEIVER: oper_cond[`QSS_OB_SRC_SWEEP] = scan_ready_i;
      default: oper_cond[`QSS_OB_SRC_SWEEP] = oper_cond_i[`QSS_OB_SRC_SWEEP];
    endcase
  end
  // Summaries read lower event words only, so a condition that has already
  // gone away still shows until its event is read and cleared.
  always_comb
  begin
    ques_cond = '0;
    ques_cond[`QSS_QB_POWER] = |power_evt_i;
    ques_cond[`QSS_QB_TEMP] = |temp_evt;
    ques_cond[`QSS_QB_FREQ] = |freq_evt_i;
    ques_cond[`QSS_QB_CAL] = |cal_evt_i;
    ques_cond[`QSS_QB_INTEG] = |integ_evt_i;
  end
  // ---------------------------------------------------------------------------
  // Event registers
  // ---------------------------------------------------------------------------
  function automatic logic ev_clr(input qss_pkg::qss_query_t q, input logic [1:0] s);
    ev_clr = q.read && q.event_q && q.sel == s;
  endfunction : ev_clr
  assign clr_ques = ev_clr(query_i, `QSS_SEL_QUES);
  assign clr_oper = ev_clr(query_i, `QSS_SEL_OPER);
  assign clr_temp = ev_clr(query_i, `QSS_SEL_TEMP);
  qss_event_reg #(
    .W(W)
  ) u_temp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(temp_cond),
    .ptr_i(temp_ptr_i),
    .ntr_i(temp_ntr_i),
    .clr_i(clr_temp),
    .event_o(temp_evt),
    .rise_o(temp_rise),
    .fall_o(temp_fall)
  );
  qss_event_reg #(
    .W(W)
  ) u_oper (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(oper_cond),
    .ptr_i(oper_ptr_i),
    .ntr_i(oper_ntr_i),
    .clr_i(clr_oper),
    .event_o(oper_evt),
    .rise_o(oper_rise),
    .fall_o(oper_fall)
  );
  // The questionable register filters its own summary transitions, so its
  // transition filters act on summary bits rather than on the lower words.
  qss_event_reg #(
    .W(W)
  ) u_ques (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(ques_cond),
    .ptr_i(ques_ptr_i),
    .ntr_i(ques_ntr_i),
    .clr_i(clr_ques),
    .event_o(ques_evt),
    .rise_o(),
    .fall_o()
  );
  // ---------------------------------------------------------------------------
  // Read port and event log
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] rdata;
    logic rvalid;
    qss_pkg::qss_event_t ev;
  } qss_top_st_t;
  qss_top_st_t s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = query_i.read;
    if (query_i.read)
    begin
      case (query_i.sel)
        `QSS_SEL_QUES: s_d.rdata = query_i.event_q ? ques_evt : ques_cond;
        `QSS_SEL_OPER: s_d.rdata = query_i.event_q ? oper_evt : oper_cond;
        `QSS_SEL_TEMP: s_d.rdata = query_i.event_q ? temp_evt : temp_cond;
        default: s_d.rdata = '0;
      endcase
    end
    // Only marked bits log; oven cold wins if both change in one cycle.
    s_d.ev = '0;
    if (oper_rise[`QSS_OB_DC_COUPLED])
      s_d.ev = '{1'b1, `QSS_ERR_DC_COUPLED};
    else if (oper_fall[`QSS_OB_DC_COUPLED])
      s_d.ev = '{1'b1, `QSS_ERR_DC_COUPLED + `QSS_ERR_CLEAR_OFS};
    if (temp_rise[`QSS_TB_OVEN_COLD])
      s_d.ev = '{1'b1, `QSS_ERR_OVEN_COLD};
    else if (temp_fall[`QSS_TB_OVEN_COLD])
      s_d.ev = '{1'b1, `QSS_ERR_OVEN_COLD + `QSS_ERR_CLEAR_OFS};
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign rdata_o = s_q.rdata;
  assign rvalid_o = s_q.rvalid;
  assign event_o = s_q.ev;
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Summary placement. Each summary must follow the lower event word only.
  a_power_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    ques_cond[`QSS_QB_POWER] == |power_evt_i)
    else $error("Power summary wrong");
  a_temp_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    ques_cond[`QSS_QB_TEMP] == |temp_evt)
    else $error("Temperature summary wrong");
  a_freq_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    ques_cond[`QSS_QB_FREQ] == |freq_evt_i)
    else $error("Frequency summary wrong");
  a_cal_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    ques_cond[`QSS_QB_CAL] == |cal_evt_i
    && ques_cond[`QSS_QB_INTEG] == |integ_evt_i)
    else $error("Cal or integrity summary wrong");
  // A warm oven with a latched event must still raise the summary.
  a_summary_source: assert property (@(posedge clk_i) disable iff (rst_i)
    !temp_cond[`QSS_TB_OVEN_COLD] && temp_evt[`QSS_TB_OVEN_COLD]
    |-> ques_cond[`QSS_QB_TEMP])
    else $error("Summary lost with condition gone");
  // Read port. Data answer one cycle after the request and hold until the next one.
  a_read_valid: assert property (@(posedge clk_i) disable iff (rst_i)
    query_i.read
    |=> rvalid_o)
    else $error("Read not answered");
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !query_i.read
    |=> !rvalid_o && $stable(rdata_o))
    else $error("Read data moved without a read");
  a_cond_read: assert property (@(posedge clk_i) disable iff (rst_i)
    query_i.read && !query_i.event_q && query_i.sel == `QSS_SEL_QUES
    |=> rdata_o == $past(ques_cond))
    else $error("Condition read wrong");
  a_evt_read: assert property (@(posedge clk_i) disable iff (rst_i)
    query_i.read && query_i.event_q && query_i.sel == `QSS_SEL_QUES
    |=> rdata_o == $past(ques_evt))
    else $error("Event read wrong");
  a_oper_read: assert property (@(posedge clk_i) disable iff (rst_i)
    query_i.read && !query_i.event_q && query_i.sel == `QSS_SEL_OPER
    |=> rdata_o == $past(oper_cond))
    else $error("Operation read wrong");
  a_temp_read: assert property (@(posedge clk_i) disable iff (rst_i)
    query_i.read && query_i.event_q && query_i.sel == `QSS_SEL_TEMP
    |=> rdata_o == $past(temp_evt))
    else $error("Temperature event read wrong");
  a_spare_read: assert property (@(posedge clk_i) disable iff (rst_i)
    query_i.read && query_i.sel == 2'h3
    |=> rdata_o == '0)
    else $error("Spare selector read not zero");
  // A condition read must leave the latched bits alone; an event read empties
  // them unless a new filtered transition arrives in the same cycle.
  a_cond_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    query_i.read && !query_i.event_q && ques_cond == $past(ques_cond)
    |=> ques_evt == $past(ques_evt))
    else $error("Condition read changed events");
  a_evt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_ques && ques_cond == $past(ques_cond)
    |=> ques_evt == '0)
    else $error("Event read did not clear");
  // Event log. Oven events take the slot when both sources move in one cycle.
  a_dc_detect: assert property (@(posedge clk_i) disable iff (rst_i)
    oper_rise[`QSS_OB_DC_COUPLED] && !temp_rise[`QSS_TB_OVEN_COLD]
    && !temp_fall[`QSS_TB_OVEN_COLD]
    |=> event_o.valid && event_o.number == `QSS_ERR_DC_COUPLED)
    else $error("DC detect not logged");
  a_dc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    oper_fall[`QSS_OB_DC_COUPLED] && !temp_rise[`QSS_TB_OVEN_COLD]
    && !temp_fall[`QSS_TB_OVEN_COLD]
    |=> event_o.valid && event_o.number == `QSS_ERR_DC_COUPLED + `QSS_ERR_CLEAR_OFS)
    else $error("DC clear not logged");
  a_oven_detect: assert property (@(posedge clk_i) disable iff (rst_i)
    temp_rise[`QSS_TB_OVEN_COLD]
    |=> event_o.valid && event_o.number == `QSS_ERR_OVEN_COLD)
    else $error("Oven detect not logged");
  a_oven_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    temp_fall[`QSS_TB_OVEN_COLD]
    |=> event_o.valid && event_o.number == `QSS_ERR_OVEN_COLD + `QSS_ERR_CLEAR_OFS)
    else $error("Oven clear not logged");
  a_oven_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    temp_rise[`QSS_TB_OVEN_COLD] && oper_rise[`QSS_OB_DC_COUPLED]
    |=> event_o.number == `QSS_ERR_OVEN_COLD)
    else $error("Oven event lost to DC event");
  a_no_log: assert property (@(posedge clk_i) disable iff (rst_i)
    !oper_rise[`QSS_OB_DC_COUPLED] && !oper_fall[`QSS_OB_DC_COUPLED]
    && !temp_rise[`QSS_TB_OVEN_COLD] && !temp_fall[`QSS_TB_OVEN_COLD]
    |=> !event_o.valid)
    else $error("Unexpected log");
  a_reserved_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    event_o.valid
    |-> event_o.number < `QSS_ERR_QUES_BASE
    || event_o.number > `QSS_ERR_QUES_BASE + `QSS_ERR_STEP * 16'h000E)
    else $error("Summary bit logged an event");
  // Operation word. Bit 10 is replaced, bit 9 in list-sequencer and receiver modes; the rest pass straight through.
  a_dc_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    oper_cond[`QSS_OB_DC_COUPLED] == dc_coupled_i)
    else $error("DC coupled bit wrong");
  a_seq_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_i == qss_pkg::QSS_LIST_SEQ
    |-> oper_cond[`QSS_OB_SRC_SWEEP] == seq_running_i)
    else $error("Sequencer bit wrong");
  a_scan_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_i == qss_pkg::QSS_RECEIVER
    |-> oper_cond[`QSS_OB_SRC_SWEEP] == scan_ready_i)
    else $error("Scan bit wrong");
  a_oper_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_i == qss_pkg::QSS_OTHER
    |-> oper_cond[`QSS_OB_SRC_SWEEP] == oper_cond_i[`QSS_OB_SRC_SWEEP])
    else $error("Sweep bit not passed through");
  // ---------------------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------------------
  c_dc_log: cover property (@(posedge clk_i) disable iff (rst_i)
    event_o.valid && event_o.number == `QSS_ERR_DC_COUPLED);
  c_oven_log: cover property (@(posedge clk_i) disable iff (rst_i)
    event_o.valid && event_o.number == `QSS_ERR_OVEN_COLD);
  c_oven_clear_log: cover property (@(posedge clk_i) disable iff (rst_i)
    event_o.valid && event_o.number == `QSS_ERR_OVEN_COLD + `QSS_ERR_CLEAR_OFS);
  c_event_read: cover property (@(posedge clk_i) disable iff (rst_i)
    clr_ques && |ques_evt);
  c_warm_summary: cover property (@(posedge clk_i) disable iff (rst_i)
    !temp_cond[`QSS_TB_OVEN_COLD] && ques_cond[`QSS_QB_TEMP]);
endmodule : qss_status_top

// >>> src/qss_map.svh
// Offsets, bit positions, event numbers and widths of the status summary block.
// Assumes the including file needs plain macros only.
`ifndef QSS_MAP_SVH
`define QSS_MAP_SVH
// ---------------------------------------------------------------------------
// Register selectors
// ---------------------------------------------------------------------------
`define QSS_SEL_QUES 2'h0
`define QSS_SEL_OPER 2'h1
`define QSS_SEL_TEMP 2'h2
// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define QSS_QB_POWER 3
`define QSS_QB_TEMP 4
`define QSS_QB_FREQ 5
`define QSS_QB_CAL 8
`define QSS_QB_INTEG 9
`define QSS_OB_SRC_SWEEP 9
`define QSS_OB_DC_COUPLED 10
`define QSS_TB_OVEN_COLD 0
// ---------------------------------------------------------------------------
// Event numbers
// ---------------------------------------------------------------------------
`define QSS_ERR_CLEAR_OFS 16'h03E8
`define QSS_ERR_QUES_BASE 16'h0259
`define QSS_ERR_STEP 16'h0002
`define QSS_ERR_DC_COUPLED 16'h02D1
`define QSS_ERR_OVEN_COLD 16'h0321
`define QSS_REG_W 15
`define QSS_RST_VAL 15'h0000
`endif

// >>> src/qss_pkg.sv
// Types shared by the status summary block.
// Assumes qss_map.svh is on the include path.
`include "qss_map.svh"
package qss_pkg;
  typedef logic [`QSS_REG_W-1:0] qss_word_t;
  typedef enum logic [1:0] {QSS_LIST_SEQ, QSS_RECEIVER, QSS_OTHER} qss_mode_t;
  typedef struct packed {
    logic valid;
    logic [15:0] number;
  } qss_event_t;
  typedef struct packed {
    logic read;
    logic event_q;
    logic [1:0] sel;
  } qss_query_t;
endpackage : qss_pkg

// >>> src/qss_event_reg.sv
// One status register: condition, transition filters and latched event bits.
// Assumes the condition word is synchronous to clk_i.
`timescale 1ns/1ps
module qss_event_reg #(
  parameter int W = 15
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] cond_i,
  input wire logic [W-1:0] ptr_i,
  input wire logic [W-1:0] ntr_i,
  input wire logic clr_i,
  output logic [W-1:0] event_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  if (W < 1 || W > 16)
  begin : g_bad_w
    $error("qss_event_reg: bad width");
  end
  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] evt;
  } qss_evreg_st_t;
  qss_evreg_st_t s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.prev = cond_i;
    // A new transition in the clear cycle survives the clear.
    s_d.evt = (clr_i ? '0 : s_q.evt) | (ptr_i & rise_o) | (ntr_i & fall_o);
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign rise_o = cond_i & ~s_q.prev;
  assign fall_o = ~cond_i & s_q.prev;
  assign event_o = s_q.evt;
  a_evt_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(ptr_i & rise_o)) |=> |event_o) else $error("Rising event not latched");
endmodule : qss_event_reg

// >>> test/qss_status_tb.sv
// Self-checking bench for the status summary block: register reads and event log.
// Assumes qss_map.svh, qss_pkg and the design modules are compiled first.
`timescale 1ns/1ps
`include "qss_map.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  qss_pkg::qss_word_t sub_evt [4];
  qss_pkg::qss_word_t oper_cond, ques_ptr, ques_ntr, oper_ptr, oper_ntr, temp_ptr, rdata_o;
  qss_pkg::qss_word_t exp_w, temp_ntr;
  logic oven_cold, dc_coupled, seq_running, scan_ready, rvalid_o;
  qss_pkg::qss_mode_t mode;
  qss_pkg::qss_query_t query;
  qss_pkg::qss_event_t event_o;
  qss_pkg::qss_word_t exp_rd [$];
  logic [15:0] exp_ev [$];
  int qb [4] = '{`QSS_QB_POWER, `QSS_QB_FREQ, `QSS_QB_CAL, `QSS_QB_INTEG};
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 32'h1600AB4F;
  // ---------------------------------------------------------------------------
  // Clock and design
  // ---------------------------------------------------------------------------
  always #5 clk_i = ~clk_i;
  qss_status_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .power_evt_i(sub_evt[0]),
    .freq_evt_i(sub_evt[1]), .cal_evt_i(sub_evt[2]), .integ_evt_i(sub_evt[3]),
    .oper_cond_i(oper_cond), .oven_cold_i(oven_cold), .dc_coupled_i(dc_coupled),
    .seq_running_i(seq_running), .scan_ready_i(scan_ready), .mode_i(mode),
    .ques_ptr_i(ques_ptr), .ques_ntr_i(ques_ntr), .oper_ptr_i(oper_ptr),
    .oper_ntr_i(oper_ntr), .temp_ptr_i(temp_ptr), .temp_ntr_i(temp_ntr),
    .query_i(query), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .event_o(event_o));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic rd(input logic [1:0] sel, input logic ev, input qss_pkg::qss_word_t exp);
    exp_rd.push_back(exp);
    query = '{read: 1'b1, event_q: ev, sel: sel};
    step(1);
    query = '0;
    step(2);
  endtask : rd
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------------------
  // Monitor
  // ---------------------------------------------------------------------------
  // An output with no note waiting is compared with a value it can never hold.
  always @(negedge clk_i)
  begin
    if (rvalid_o === 1'b1)
      cmp({1'b0, rdata_o}, exp_rd.size() > 0 ? {1'b0, exp_rd.pop_front()} : 16'hFFFF);
    if (event_o.valid === 1'b1)
      cmp(event_o.number, exp_ev.size() > 0 ? exp_ev.pop_front() : 16'hFFFF);
  end
  initial
  begin
    #50000;
    n_mismatch++;
    summarize();
  end
  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  initial
  begin
    foreach (sub_evt[i]) sub_evt[i] = '0;
    {oper_cond, ques_ptr, ques_ntr, oper_ptr, oper_ntr, temp_ptr, temp_ntr} = '0;
    {oven_cold, dc_coupled, seq_running, scan_ready} = '0;
    mode = qss_pkg::QSS_OTHER;
    query = '0;
    step(5);
    rst_i = 1'b0;
    step(1);
    for (int i = 0; i < 4; i++)
    begin
      sub_evt[i] = 15'($random(seed)) | 15'h0001;
      step(2);
      rd(`QSS_SEL_QUES, 1'b0, 15'h0001 << qb[i]);
      sub_evt[i] = '0;
      step(2);
    end
    ques_ptr = 15'h7FFF;
    sub_evt[0] = 15'h0004;
    step(3);
    rd(`QSS_SEL_QUES, 1'b1, 15'h0008);
    rd(`QSS_SEL_QUES, 1'b1, 15'h0000);
    rd(`QSS_SEL_QUES, 1'b0, 15'h0008);
    rd(`QSS_SEL_QUES, 1'b0, 15'h0008);
    {ques_ptr, ques_ntr} = {15'h0000, 15'h7FFF};
    sub_evt[0] = '0;
    step(3);
    rd(`QSS_SEL_QUES, 1'b1, 15'h0008);
    ques_ntr = '0;
    {temp_ptr, temp_ntr} = {15'h7FFF, 15'h7FFF};
    exp_ev.push_back(`QSS_ERR_OVEN_COLD);
    oven_cold = 1'b1;
    step(3);
    rd(`QSS_SEL_TEMP, 1'b0, 15'h0001);
    rd(`QSS_SEL_TEMP, 1'b1, 15'h0001);
    exp_ev.push_back(`QSS_ERR_OVEN_COLD + `QSS_ERR_CLEAR_OFS);
    oven_cold = 1'b0;
    step(3);
    // The summary keeps showing the latched temperature event after the oven warms.
    rd(`QSS_SEL_QUES, 1'b0, 15'h0010);
    rd(`QSS_SEL_TEMP, 1'b1, 15'h0001);
    rd(`QSS_SEL_QUES, 1'b0, 15'h0000);
    rd(`QSS_SEL_TEMP, 1'b1, 15'h0000);
    exp_ev.push_back(`QSS_ERR_DC_COUPLED);
    dc_coupled = 1'b1;
    step(3);
    rd(`QSS_SEL_OPER, 1'b0, 15'h0400);
    exp_ev.push_back(`QSS_ERR_DC_COUPLED + `QSS_ERR_CLEAR_OFS);
    dc_coupled = 1'b0;
    step(3);
    for (int i = 0; i < 9; i++)
    begin
      mode = qss_pkg::qss_mode_t'(i % 3);
      oper_cond = 15'($random(seed));
      {oper_ptr, oper_ntr} = 30'($random(seed));
      {seq_running, scan_ready} = 2'($random(seed));
      exp_w = oper_cond & 15'h79FF;
      if (i % 3 == 0)
        exp_w[9] = seq_running;
      else if (i % 3 == 1)
        exp_w[9] = scan_ready;
      else
        exp_w[9] = oper_cond[9];
      step(2);
      rd(`QSS_SEL_OPER, 1'b0, exp_w);
    end
    rd(2'h3, 1'b0, 15'h0000);
    step(3);
    if (exp_rd.size() > 0 || exp_ev.size() > 0)
      n_mismatch++;
    summarize();
  end
endmodule : testbench
